// ---- core/timer2_capture_reload_baud.sv ----
/*
  Sixteen-bit timer/counter with capture, auto-reload and baud-rate
  generation for serial port 0, reached over the special-function
  register port. Assumes pins are asynchronous and that the serial port
  samples the baud ticks on ref_clk.
*/
`timescale 1ns/1ns
`include "timer2_consts.svh"

module timer2_capture_reload_baud (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       fast_prescale_select,
  input  wire logic [1:0] sp0_mode,
  input  wire logic       count_input_pin,
  input  wire logic       external_trigger_pin,
  output logic            overflow_pulse_pin,
  output logic            rx_baud_tick,
  output logic            tx_baud_tick,
  output logic            overflow_flag,
  output logic            external_flag
);

  timer2_pkg::core_state_t state;      // Registered state
  timer2_pkg::core_state_t next_state; // Next value
  timer2_pkg::mode_t       mode;       // Decoded operating mode

  timer2_pin_if pin_bus ();            // Pin edges from the synchroniser

  logic       count_fall;   // Count pin falling edge
  logic       trigger_fall; // Trigger pin falling edge
  logic       tick;         // Counter advances this cycle
  logic       wrap;         // Count steps past all ones
  logic       trig_event;   // Trigger edge that is honoured
  logic       sp0_async;    // Serial port 0 takes timer clocks
  logic [3:0] div_last;     // Prescale terminal count

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  assign pin_bus.raw = {external_trigger_pin, count_input_pin};

  timer2_pin_sync #(.PINS(2)) timer2_pin_sync_i (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pins    (pin_bus.sync_side)
  );

  assign count_fall   = pin_bus.fall[0];
  assign trigger_fall = pin_bus.fall[1];

  ////////////////////////////////////////////////////////////////////////
  // Mode decode; baud selects outrank the capture select
  always_comb begin
    if (!state.control[`T2_BIT_RUN_ENABLE]) begin
      mode = timer2_pkg::MODE_STOPPED;
    end else if (state.control[`T2_BIT_TX_BAUD_SELECT] ||
                 state.control[`T2_BIT_RX_BAUD_SELECT]) begin
      mode = timer2_pkg::MODE_BAUD;
    end else if (state.control[`T2_BIT_CAPTURE_SELECT]) begin
      mode = timer2_pkg::MODE_CAPTURE;
    end else begin
      mode = timer2_pkg::MODE_RELOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Count source: prescaled clock or pin edges
  always_comb begin
    if (mode == timer2_pkg::MODE_BAUD) begin
      div_last = `T2_DIV_BAUD_LAST;
    end else if (fast_prescale_select) begin
      div_last = `T2_DIV_FAST_LAST;
    end else begin
      div_last = `T2_DIV_SLOW_LAST;
    end
  end

  always_comb begin
    if (mode == timer2_pkg::MODE_STOPPED) begin
      tick = 1'b0;
    end else if (state.control[`T2_BIT_COUNTER_SELECT]) begin
      tick = count_fall;
    end else begin
      tick = (state.prescale == div_last);
    end
  end

  assign wrap = tick && (state.count == `T2_COUNT_ALL_ONE);

  // Trigger edges count only with the external enable set
  assign trig_event = trigger_fall &&
                      state.control[`T2_BIT_EXT_EVENT_EN];

  // Only async modes 1 and 3 of port 0 take timer clocks
  assign sp0_async = (sp0_mode == `T2_SP0_MODE_1) ||
                     (sp0_mode == `T2_SP0_MODE_3);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_state                = state;
    next_state.overflow_pulse = 1'b0;
    next_state.rx_tick        = 1'b0;
    next_state.tx_tick        = 1'b0;

    // Prescaler runs only while clock-timed and running
    if (mode == timer2_pkg::MODE_STOPPED ||
        state.control[`T2_BIT_COUNTER_SELECT] ||
        state.prescale >= div_last) begin
      next_state.prescale = 4'h0;
    end else begin
      next_state.prescale = state.prescale + 4'h1;
    end

    // Counter step
    if (tick) begin
      next_state.count = state.count + 16'h0001;
    end

    case (mode)
      timer2_pkg::MODE_BAUD: begin
        if (wrap) begin
          // Reload and shift pulse, flag untouched
          next_state.count   = state.reload_pair;
          next_state.rx_tick = sp0_async &&
            state.control[`T2_BIT_RX_BAUD_SELECT];
          next_state.tx_tick = sp0_async &&
            state.control[`T2_BIT_TX_BAUD_SELECT];
        end
      end
      timer2_pkg::MODE_RELOAD: begin
        if (wrap || trig_event) begin
          next_state.count = state.reload_pair;
        end
        if (wrap) begin
          next_state.overflow_pulse = 1'b1;
        end
      end
      timer2_pkg::MODE_CAPTURE: begin
        if (wrap) begin
          next_state.overflow_pulse = 1'b1;
        end
        if (trig_event) begin
          next_state.reload_pair = state.count;
        end
      end
      timer2_pkg::MODE_STOPPED: begin
        // Capture still possible; reload would move a held count
        if (trig_event && state.control[`T2_BIT_CAPTURE_SELECT] &&
            !state.control[`T2_BIT_TX_BAUD_SELECT] &&
            !state.control[`T2_BIT_RX_BAUD_SELECT]) begin
          next_state.reload_pair = state.count;
        end
      end
      default: begin
        next_state.count = state.count;
      end
    endcase

    // Software writes; a count byte write beats the count step
    if (sfr_wr) begin
      case (sfr_addr)
        `T2_ADDR_MODE_CONTROL: next_state.control         = sfr_wdata;
        `T2_ADDR_RELOAD_LOW:   next_state.reload_pair[7:0]  = sfr_wdata;
        `T2_ADDR_RELOAD_HIGH:  next_state.reload_pair[15:8] = sfr_wdata;
        `T2_ADDR_COUNT_LOW:    next_state.count[7:0]        = sfr_wdata;
        `T2_ADDR_COUNT_HIGH:   next_state.count[15:8]       = sfr_wdata;
        default:               next_state.control         = state.control;
      endcase
    end

    // Hardware flag sets win over a clearing write
    if (wrap && mode != timer2_pkg::MODE_BAUD) begin
      next_state.control[`T2_BIT_OVERFLOW_FLAG] = 1'b1;
    end
    if (trig_event) begin
      next_state.control[`T2_BIT_EXTERNAL_FLAG] = 1'b1;
    end

    // Read answer, one cycle after the strobe
    if (sfr_rd) begin
      case (sfr_addr)
        `T2_ADDR_MODE_CONTROL: next_state.read_data = state.control;
        `T2_ADDR_RELOAD_LOW:   next_state.read_data = state.reload_pair[7:0];
        `T2_ADDR_RELOAD_HIGH:  next_state.read_data = state.reload_pair[15:8];
        `T2_ADDR_COUNT_LOW:    next_state.read_data = state.count[7:0];
        `T2_ADDR_COUNT_HIGH:   next_state.read_data = state.count[15:8];
        default:               next_state.read_data = `T2_RESET_BYTE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{control:        `T2_RESET_CONTROL,
                 reload_pair:    `T2_RESET_COUNT,
                 count:          `T2_RESET_COUNT,
                 prescale:       4'h0,
                 overflow_pulse: 1'b0,
                 rx_tick:        1'b0,
                 tx_tick:        1'b0,
                 read_data:      `T2_RESET_BYTE};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  assign sfr_rdata          = state.read_data;
  assign overflow_pulse_pin = state.overflow_pulse;
  assign rx_baud_tick       = state.rx_tick;
  assign tx_baud_tick       = state.tx_tick;
  assign overflow_flag      = state.control[`T2_BIT_OVERFLOW_FLAG];
  assign external_flag      = state.control[`T2_BIT_EXTERNAL_FLAG];

endmodule

// ---- core/timer2_consts.svh ----
/*
  Constants of the capture/reload/baud timer: register offsets, control
  bit positions, reset values and prescale counts, all as macros.
  Assumes it is included by bare name from the package and the modules.
*/
// How it works
// - Counter holds whenever run_enable is clear
// - Any baud select forces auto-reload, ignores capture_not_reload
// - Capture select picks capture, else 16-bit auto-reload
// - counter_not_timer picks divided clock or pin falls
// - Non-baud overflow sets flag, one-cycle pulse pin
// - Capture mode trigger fall copies count into pair
// - Auto-reload overflow sets flag, reloads from pair
// - Reload mode trigger fall forces immediate reload
// - Baud overflow gives shift pulse and reload, no flag
// - Baud mode: only trigger falls set external flag
// - Receive and transmit selects route overflow independently
// - Baud mode counts at half clock unless pin-clocked
// - Baud ticks serve serial port 0, modes 1, 3
// - Trigger events set external flag; software clears
// - Overflow flag set only outside baud; software clears
// - fast_prescale_select picks divide by 4 or 12
// - Trigger pin ignored while external_event_enable clear
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// Register offsets on the special-function register port
`define T2_ADDR_MODE_CONTROL 8'hC8
`define T2_ADDR_RELOAD_LOW   8'hCA
`define T2_ADDR_RELOAD_HIGH  8'hCB
`define T2_ADDR_COUNT_LOW    8'hCC
`define T2_ADDR_COUNT_HIGH   8'hCD

// Bit positions in timer_mode_control
`define T2_BIT_OVERFLOW_FLAG  7
`define T2_BIT_EXTERNAL_FLAG  6
`define T2_BIT_RX_BAUD_SELECT 5
`define T2_BIT_TX_BAUD_SELECT 4
`define T2_BIT_EXT_EVENT_EN   3
`define T2_BIT_RUN_ENABLE     2
`define T2_BIT_COUNTER_SELECT 1
`define T2_BIT_CAPTURE_SELECT 0

// Reset values
`define T2_RESET_CONTROL 8'h00
`define T2_RESET_BYTE    8'h00
`define T2_RESET_COUNT   16'h0000
`define T2_COUNT_ALL_ONE 16'hFFFF

// Prescale divisors of the core clock, as terminal counts
`define T2_DIV_SLOW_LAST 4'hB
`define T2_DIV_FAST_LAST 4'h3
`define T2_DIV_BAUD_LAST 4'h1

// Serial port 0 modes that take a timer baud clock
`define T2_SP0_MODE_1 2'h1
`define T2_SP0_MODE_3 2'h3

`endif

// ---- core/timer2_pin_if.sv ----
/*
  Carrier between the timer core and its pin synchroniser.
  Bit 0 is the count input pin, bit 1 the external trigger pin.
*/
`timescale 1ns/1ns

interface timer2_pin_if;
  logic [1:0] raw;  // Unsynchronised pin levels
  logic [1:0] fall; // One-cycle falling-edge pulses

  modport sync_side  (input raw, output fall);
  modport timer_side (output raw, input fall);
endinterface

// ---- core/timer2_pin_sync.sv ----
/*
  Two-flop synchroniser and falling-edge detector for the timer pins.
  Assumes pins are asynchronous to ref_clk and change slower than it.
*/
`timescale 1ns/1ns
`include "timer2_consts.svh"

module timer2_pin_sync #(
  parameter int PINS = 2
) (
  input  wire logic      ref_clk,
  input  wire logic      arst_n,
  timer2_pin_if.sync_side pins
);

  timer2_pkg::sync_state_t state;      // Registered state
  timer2_pkg::sync_state_t next_state; // Next value

  ////////////////////////////////////////////////////////////////////////
  // Shift chain; only stage2 and stage3 feed any logic
  always_comb begin
    next_state        = state;
    next_state.stage1 = pins.raw;
    next_state.stage2 = state.stage1;
    next_state.stage3 = state.stage2;
  end

  // Idle-high reset avoids a false edge after release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= '{stage1: 2'h3, stage2: 2'h3, stage3: 2'h3};
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One pulse per falling edge, per pin
  for (genvar i = 0; i < PINS; i++) begin : g_edge
    assign pins.fall[i] = state.stage3[i] & ~state.stage2[i];
  end

endmodule

// ---- core/timer2_pkg.sv ----
/*
  Types of the capture/reload/baud timer: operating modes and state.
  Assumes timer2_consts.svh is on the include path.
*/
`include "timer2_consts.svh"

package timer2_pkg;

  // Operating modes decoded from the control register
  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_BAUD,
    MODE_RELOAD,
    MODE_CAPTURE
  } mode_t;

  // Whole state of the timer core
  typedef struct packed {
    logic [7:0]  control;        // timer_mode_control
    logic [15:0] reload_pair;    // High byte, low byte
    logic [15:0] count;          // count_high, count_low
    logic [3:0]  prescale;       // Core clock divider
    logic        overflow_pulse; // Registered pulse pin
    logic        rx_tick;        // Receive baud clock pulse
    logic        tx_tick;        // Transmit baud clock pulse
    logic [7:0]  read_data;      // Register read answer
  } core_state_t;

  // State of the pin synchroniser, one bit per pin
  typedef struct packed {
    logic [1:0] stage1; // First capture flop
    logic [1:0] stage2; // Stable sample
    logic [1:0] stage3; // Previous stable sample
  } sync_state_t;

endpackage

// ---- verif/timer2_capture_reload_baud_bench.sv ----
/*
  Self-checking bench of the capture/reload/baud timer.
  Assumes the far-end model and the bound checker are compiled first.
*/
`timescale 1ns/1ns
`include "timer2_consts.svh"

module timer2_capture_reload_baud_bench;
  logic       ref_clk, arst_n, sfr_wr, sfr_rd;   // Clock, reset, strobes
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d; // Bus and last read
  logic       fast_prescale_select;              // Divide 4 when set
  logic [1:0] sp0_mode;                          // Serial port 0 mode
  logic       count_input_pin, external_trigger_pin, overflow_pulse_pin;
  logic       rx_baud_tick, tx_baud_tick, overflow_flag, external_flag;
  logic [2:0] ev;                                // Events measured by gap
  logic [7:0] n;                                 // Last measured period
  int         mismatches = 0;
  int         n_compared = 0;
  assign ev = {tx_baud_tick, rx_baud_tick, overflow_pulse_pin};

  timer2_capture_reload_baud timer2_capture_reload_baud_i (.ref_clk,
    .arst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
    .fast_prescale_select, .sp0_mode, .count_input_pin,
    .external_trigger_pin, .overflow_pulse_pin, .rx_baud_tick,
    .tx_baud_tick, .overflow_flag, .external_flag);
  timer2_far_end timer2_far_end_i (.ref_clk, .rx_baud_tick, .tx_baud_tick,
    .count_input_pin, .external_trigger_pin);

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge ref_clk);
    sfr_addr  <= a;
    sfr_wdata <= v;
    sfr_wr    <= 1'h1;
    @(posedge ref_clk);
    sfr_wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_rd   <= 1'h1;
    @(posedge ref_clk);
    sfr_rd <= 1'h0;
    #1 d = sfr_rdata;
  endtask
  // Cycles between two events; 0 if fewer than two. Settles mode first.
  task automatic gap(input int s);
    int seen;
    seen = 0;
    n = 8'h00;
    repeat (16) @(posedge ref_clk);
    repeat (60) begin
      @(posedge ref_clk);
      #1;
      if (seen == 1) n++;
      if (ev[s] && seen < 2) seen++;
    end
    if (seen < 2) n = 8'h00;
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`T2_ADDR_MODE_CONTROL);
    check("control", d, 8'h00);
    rd(8'hC9);
    check("unmapped", d, 8'h00);
  endtask
  // Reload of all ones overflows on every tick: period shows divider
  task automatic t_rates();
    wr(`T2_ADDR_RELOAD_LOW, 8'hFF);
    wr(`T2_ADDR_RELOAD_HIGH, 8'hFF);
    wr(`T2_ADDR_COUNT_LOW, 8'hFF);
    wr(`T2_ADDR_COUNT_HIGH, 8'hFF);
    fast_prescale_select <= 1'h1;
    wr(`T2_ADDR_MODE_CONTROL, 8'h04);
    gap(0);
    check("period fast", n, 8'h04);
    check("overflow flag", {7'h00, overflow_flag}, 8'h01);
    @(posedge ref_clk); // Inputs move only on a clock edge
    fast_prescale_select <= 1'h0;
    gap(0);
    check("period slow", n, 8'h0C);
    wr(`T2_ADDR_MODE_CONTROL, 8'h05);
    repeat (30) @(posedge ref_clk);
    rd(`T2_ADDR_COUNT_HIGH);
    check("capture wrap", d, 8'h00);
    check("flag again", {7'h00, overflow_flag}, 8'h01);
  endtask
  task automatic t_baud();
    int rx0;
    wr(`T2_ADDR_MODE_CONTROL, 8'h00);
    #1; // Flag register updates after the write edge
    check("flag cleared", {7'h00, overflow_flag}, 8'h00);
    wr(`T2_ADDR_COUNT_LOW, 8'hFF);
    wr(`T2_ADDR_COUNT_HIGH, 8'hFF);
    sp0_mode <= 2'h1;
    rx0 = timer2_far_end_i.rx_ticks;
    wr(`T2_ADDR_MODE_CONTROL, 8'h15);
    gap(2);
    check("tx period", n, 8'h02);
    check("rx idle", 8'(timer2_far_end_i.rx_ticks - rx0), 8'h00);
    check("no flag", {7'h00, overflow_flag}, 8'h00);
    @(posedge ref_clk); // Inputs move only on a clock edge
    sp0_mode <= 2'h3;
    wr(`T2_ADDR_MODE_CONTROL, 8'h25);
    gap(1);
    check("rx period", n, 8'h02);
    @(posedge ref_clk); // Inputs move only on a clock edge
    sp0_mode <= 2'h0;
    gap(1);
    check("mode 0 silent", n, 8'h00);
  endtask
  task automatic t_trigger();
    wr(`T2_ADDR_MODE_CONTROL, 8'h01);
    wr(`T2_ADDR_COUNT_LOW, 8'hCD);
    wr(`T2_ADDR_COUNT_HIGH, 8'hAB);
    timer2_far_end_i.falls(1'h1, 1);
    rd(`T2_ADDR_RELOAD_LOW);
    check("no capture", d, 8'hFF);
    check("no ext flag", {7'h00, external_flag}, 8'h00);
    wr(`T2_ADDR_MODE_CONTROL, 8'h09);
    timer2_far_end_i.falls(1'h1, 1);
    rd(`T2_ADDR_RELOAD_LOW);
    check("capture low", d, 8'hCD);
    rd(`T2_ADDR_RELOAD_HIGH);
    check("capture high", d, 8'hAB);
    check("ext flag", {7'h00, external_flag}, 8'h01);
    rd(`T2_ADDR_COUNT_LOW);
    check("held count", d, 8'hCD);
    wr(`T2_ADDR_COUNT_LOW, 8'h00);
    wr(`T2_ADDR_COUNT_HIGH, 8'h00);
    wr(`T2_ADDR_MODE_CONTROL, 8'h0C);
    timer2_far_end_i.falls(1'h1, 1);
    rd(`T2_ADDR_COUNT_HIGH);
    check("forced reload", d, 8'hAB);
  endtask
  task automatic t_counter();
    wr(`T2_ADDR_MODE_CONTROL, 8'h00);
    wr(`T2_ADDR_COUNT_LOW, 8'h00);
    wr(`T2_ADDR_MODE_CONTROL, 8'h06);
    timer2_far_end_i.falls(1'h0, 3);
    rd(`T2_ADDR_COUNT_LOW);
    check("pin count", d, 8'h03);
  endtask

  // Main sequence; reset held 6 cycles, inputs driven at the edge
  initial begin
    arst_n               = 1'h0;
    sfr_addr             = 8'h00;
    sfr_wdata            = 8'h00;
    sfr_wr               = 1'h0;
    sfr_rd               = 1'h0;
    fast_prescale_select = 1'h0;
    sp0_mode             = 2'h0;
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'h1;
    t_reset();
    t_rates();
    t_baud();
    t_trigger();
    t_counter();
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    end_sim();
  end
endmodule

// ---- verif/timer2_capture_reload_baud_props.sv ----
/*
  Port checker of the capture/reload/baud timer.
  Assumes it is bound to timer2_capture_reload_baud.
*/
`timescale 1ns/1ns
`include "timer2_consts.svh"

module timer2_port_checker (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_rdata,
  input wire logic [1:0] sp0_mode,
  input wire logic       external_trigger_pin,
  input wire logic       overflow_pulse_pin,
  input wire logic       rx_baud_tick,
  input wire logic       tx_baud_tick,
  input wire logic       overflow_flag,
  input wire logic       external_flag
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  logic       trig_q;     // Trigger pin one edge ago
  logic [3:0] since_fall; // Edges since the pin fell, saturating
  logic       ctl_wr;     // Software write to the control register
  assign ctl_wr = sfr_wr && sfr_addr == `T2_ADDR_MODE_CONTROL;

  // Raw trigger age; saturates so a long idle never wraps to "recent"
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_q     <= 1'h1;
      since_fall <= 4'hF;
    end else begin
      trig_q <= external_trigger_pin;
      if (trig_q && !external_trigger_pin) since_fall <= 4'h0;
      else if (since_fall != 4'hF) since_fall <= since_fall + 4'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  chk_pulse_one_cycle: assert property (
    overflow_pulse_pin |=> !overflow_pulse_pin) else $error("pulse long");
  chk_pulse_sets_flag: assert property (
    overflow_pulse_pin |-> overflow_flag) else $error("pulse no flag");
  chk_baud_no_pulse: assert property (
    (rx_baud_tick || tx_baud_tick) |-> !overflow_pulse_pin)
    else $error("pulse in baud");
  chk_tick_sp_mode: assert property (
    (rx_baud_tick || tx_baud_tick) |-> $past(sp0_mode) inside {2'h1, 2'h3})
    else $error("tick in wrong serial mode");
  chk_flag_cause: assert property (
    $rose(overflow_flag) |-> overflow_pulse_pin ||
    $past(ctl_wr && sfr_wdata[7])) else $error("flag without cause");
  chk_ext_flag_cause: assert property (
    $rose(external_flag) |-> since_fall <= 4'h8 ||
    $past(ctl_wr && sfr_wdata[6])) else $error("ext flag no cause");
  chk_unmapped_zero: assert property (
    sfr_rd && !(sfr_addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD})
    |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (
    !sfr_rd |=> $stable(sfr_rdata)) else $error("read data moved");
  chk_flag_readback: assert property (
    sfr_rd && sfr_addr == `T2_ADDR_MODE_CONTROL |=>
    sfr_rdata[7:6] == $past({overflow_flag, external_flag}))
    else $error("flag readback wrong");
endmodule

bind timer2_capture_reload_baud timer2_port_checker timer2_port_checker_i (
  .ref_clk, .arst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata,
  .sp0_mode, .external_trigger_pin, .overflow_pulse_pin, .rx_baud_tick,
  .tx_baud_tick, .overflow_flag, .external_flag);

// ---- verif/timer2_far_end.sv ----
/*
  Far-side model: slow external logic on the count and trigger pins,
  and serial port 0 taking the baud ticks.
  Assumes the bench calls its task from one process only.
*/
`timescale 1ns/1ns

module timer2_far_end (
  input  wire logic ref_clk,
  input  wire logic rx_baud_tick,
  input  wire logic tx_baud_tick,
  output logic      count_input_pin,
  output logic      external_trigger_pin
);
  int rx_ticks; // Receive shift clocks taken
  int tx_ticks; // Transmit shift clocks taken

  // Pins idle high, so reset never shows a false fall
  initial begin
    count_input_pin      = 1'h1;
    external_trigger_pin = 1'h1;
    rx_ticks             = 0;
    tx_ticks             = 0;
  end

  // Serial port side: one shift clock per tick
  always @(posedge ref_clk) begin
    if (rx_baud_tick) rx_ticks <= rx_ticks + 1;
    if (tx_baud_tick) tx_ticks <= tx_ticks + 1;
  end

  // Falls on one pin; each level held 3 cycles so none is missed
  task automatic falls(input logic trig, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      if (trig) external_trigger_pin <= 1'h0;
      else count_input_pin <= 1'h0;
      repeat (3) @(posedge ref_clk);
      external_trigger_pin <= 1'h1;
      count_input_pin      <= 1'h1;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule
